// ==== logic/vectored_interrupt_control.sv ====
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "vic_regs.svh"
module vectored_interrupt_control (
   input wire logic core_clk_i,
   input wire logic reset_i,
   // apb slave
   input wire vic_pkg::apb_req_type apb_req_i,
   output vic_pkg::apb_rsp_type apb_rsp_o,
   // external interrupt pins, asynchronous
   input wire logic ext_pin0_i,
   input wire logic ext_pin1_i,
   // peripheral flags, same clock, bank2 then bank1 then bank0
   input wire logic [23:0] source_flag_i,
   // core service context events, one-cycle pulses
   input wire logic isr_enter_high_i,
   input wire logic isr_enter_low_i,
   input wire logic isr_return_i,
   // vector address computed by the core at entry
   input wire logic [20:0] vector_address_i,
   // configuration setting for one-way lock, static
   input wire logic one_way_lock_i,
   // forwarded requests toward the core
   output logic [23:0] source_request_o,
   output logic [20:0] vector_base_o,
   output logic vector_locked_o,
   output logic shadow_main_select_o,
   output logic [1:0] interrupt_state_o,
   output logic irq_o
);

   // software visible storage
   logic [7:0] source_enable_bank0; // per-source enables, bank 0
   logic [7:0] source_enable_bank1; // bank 1, bit 0 is pin zero
   logic [7:0] source_enable_bank2; // bank 2, bits 3:1 absent
   logic [20:0] vector_table_base; // upper, middle, lower parts
   logic [20:0] vector_table_address_readback; // read-only copy
   logic vector_lock_bit; // guards the base
   logic shadow_access_switch; // shadow context steering
   logic ext_pin0_edge_select; // 1 rising, 0 falling
   logic ext_pin1_edge_select; // 1 rising, 0 falling
   logic [`EVENT_WIDTH-1:0] event_status; // sticky, write one to clear
   logic [`EVENT_WIDTH-1:0] event_mask; // 1 lets the bit reach irq_o
   vic_pkg::ctx_state_type ctx_state; // service context
   vic_pkg::key_state_type key_state; // unlock progress
   logic one_way_lock; // setting caught after reset
   logic one_way_caught; // setting sampled once

   // pin synchronisers and edge history
   logic [1:0] pin0_sync; // [0] only feeds [1]
   logic [1:0] pin1_sync;
   logic pin0_prev; // previous synchronised level
   logic pin1_prev;
   logic pin0_event; // selected edge seen
   logic pin1_event;

   // bus decode
   logic access_cycle; // access phase, completes this edge
   logic write_cycle;
   logic [11:0] reg_index; // word index from the byte address
   logic addr_word_aligned;
   logic hit_any; // address lands on a register
   logic [7:0] wbyte; // low write byte
   logic [31:0] next_rdata;

   // lock decisions
   logic lock_write; // write aimed at the lock register
   logic lock_write_allowed; // sequence armed and not one-way refused
   logic base_write; // write aimed at the base
   logic [`EVENT_WIDTH-1:0] event_set; // hardware set pulses

   // access phase: psel and penable both high
   assign access_cycle = apb_req_i.psel && apb_req_i.penable;
   // writes change register state; a read only drops the unlock sequence
   assign write_cycle = access_cycle && apb_req_i.pwrite;
   // word index; the two lane bits are dropped here
   assign reg_index = apb_req_i.paddr[13:2];
   // lanes must be zero and the top bits clear, else no register is hit
   assign addr_word_aligned = (apb_req_i.paddr[1:0] == 2'b00) && !apb_req_i.paddr[15]
      && !apb_req_i.paddr[14];
   // every register lives in the low byte apart from the base and its readback
   assign wbyte = apb_req_i.pwdata[7:0];

   // every register answers at once; no wait states
   always_comb begin
      hit_any = 1'b1;
      next_rdata = 32'h00000000;
      unique case (reg_index)
         `IDX_SHADOW_CONTEXT_SELECT: begin
            next_rdata[`SHADOW_SWITCH_BIT] = shadow_access_switch;
         end
         `IDX_VECTOR_BASE_LOCK: begin
            next_rdata[`LOCK_BIT] = vector_lock_bit;
         end
         `IDX_VECTOR_TABLE_ADDRESS_READBACK: begin
            next_rdata[20:0] = vector_table_address_readback;
         end
         `IDX_VECTOR_TABLE_BASE: begin
            next_rdata[20:0] = vector_table_base;
         end
         `IDX_SOURCE_ENABLE_BANK0: begin
            next_rdata[7:0] = source_enable_bank0;
         end
         `IDX_SOURCE_ENABLE_BANK1: begin
            next_rdata[7:0] = source_enable_bank1;
         end
         `IDX_SOURCE_ENABLE_BANK2: begin
            next_rdata[7:0] = source_enable_bank2;
         end
         `IDX_EXT_EDGE_CONTROL: begin
            next_rdata[`EDGE_PIN0_BIT] = ext_pin0_edge_select;
            next_rdata[`EDGE_PIN1_BIT] = ext_pin1_edge_select;
         end
         `IDX_INTERRUPT_STATE_STATUS: begin
            // context field sits in bits 7:6, the top two bits of the low byte
            next_rdata[`STATE_FIELD_LSB+:2] = interrupt_state_o;
         end
         `IDX_EVENT_STATUS: begin
            next_rdata[`EVENT_WIDTH-1:0] = event_status;
         end
         `IDX_EVENT_MASK: begin
            next_rdata[`EVENT_WIDTH-1:0] = event_mask;
         end
         `IDX_UNLOCK_KEY: begin
            // key register reads as zero so it cannot be replayed
            next_rdata = 32'h00000000;
         end
         default: begin
            // unmapped index answers with an error and reads zero
            hit_any = 1'b0;
         end
      endcase
      // a misaligned access never reads a register
      if (!addr_word_aligned) begin
         hit_any = 1'b0;
         next_rdata = 32'h00000000;
      end
   end

   // answer: ready at once, error on an unmapped or misaligned address
   always_comb begin
      apb_rsp_o.pready = 1'b1;
      apb_rsp_o.pslverr = access_cycle && !hit_any;
      apb_rsp_o.prdata = (access_cycle && !apb_req_i.pwrite) ? next_rdata : 32'h00000000;
   end

   // a write hits a register only when aligned and mapped
   function automatic logic wr_hit(input logic [11:0] idx);
      wr_hit = write_cycle && addr_word_aligned && (reg_index == idx);
   endfunction

   assign lock_write = wr_hit(`IDX_VECTOR_BASE_LOCK);
   assign base_write = wr_hit(`IDX_VECTOR_TABLE_BASE);
   // clearing a set lock is refused once one-way is in force
   assign lock_write_allowed = (key_state == vic_pkg::KEY_ARMED)
      && !(one_way_lock && vector_lock_bit && !wbyte[`LOCK_BIT]);

   // unlock sequence: two key writes, then the very next transfer
   // must be the lock write; any other transfer drops the sequence
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         key_state <= vic_pkg::KEY_IDLE;
      end else if (access_cycle) begin
         if (wr_hit(`IDX_UNLOCK_KEY) && wbyte == `UNLOCK_KEY_FIRST) begin
            // first key byte always restarts the sequence
            key_state <= vic_pkg::KEY_FIRST_SEEN;
         end else if (wr_hit(`IDX_UNLOCK_KEY) && wbyte == `UNLOCK_KEY_SECOND
            && key_state == vic_pkg::KEY_FIRST_SEEN) begin
            // second key byte arms only straight after the first
            key_state <= vic_pkg::KEY_ARMED;
         end else begin
            // any other transfer, the lock write too, disarms
            key_state <= vic_pkg::KEY_IDLE;
         end
      end
   end

   // one-way setting is caught at the first edge after reset release;
   // later changes on the input are ignored until the next reset
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         one_way_caught <= 1'b0;
         one_way_lock <= 1'b0;
      end else if (!one_way_caught) begin
         one_way_caught <= 1'b1;
         one_way_lock <= one_way_lock_i;
      end
   end

   // lock bit
   // a refused write leaves the bit alone and raises an event instead
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         vector_lock_bit <= 1'b0;
      end else if (lock_write && lock_write_allowed) begin
         vector_lock_bit <= wbyte[`LOCK_BIT];
      end
   end

   // vector base: all three parts share the same lock
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         vector_table_base <= `RESET_BASE;
      end else if (base_write && !vector_lock_bit) begin
         vector_table_base <= apb_req_i.pwdata[20:0];
      end
   end

   // readback follows the core, never the bus
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         vector_table_address_readback <= `RESET_BASE;
      end else if (isr_enter_high_i || isr_enter_low_i) begin
         vector_table_address_readback <= vector_address_i;
      end
   end

   // enable banks; unimplemented bank 2 bits stay zero
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         source_enable_bank0 <= `RESET_BYTE;
         source_enable_bank1 <= `RESET_BYTE;
         source_enable_bank2 <= `RESET_BYTE;
      end else begin
         if (wr_hit(`IDX_SOURCE_ENABLE_BANK0)) begin
            source_enable_bank0 <= wbyte;
         end
         if (wr_hit(`IDX_SOURCE_ENABLE_BANK1)) begin
            source_enable_bank1 <= wbyte;
         end
         if (wr_hit(`IDX_SOURCE_ENABLE_BANK2)) begin
            source_enable_bank2 <= wbyte & `BANK2_IMPL_MASK;
         end
      end
   end

   // shadow switch and edge selects
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         shadow_access_switch <= 1'b0;
         ext_pin0_edge_select <= 1'b0;
         ext_pin1_edge_select <= 1'b0;
      end else begin
         if (wr_hit(`IDX_SHADOW_CONTEXT_SELECT)) begin
            shadow_access_switch <= wbyte[`SHADOW_SWITCH_BIT];
         end
         if (wr_hit(`IDX_EXT_EDGE_CONTROL)) begin
            ext_pin0_edge_select <= wbyte[`EDGE_PIN0_BIT];
            ext_pin1_edge_select <= wbyte[`EDGE_PIN1_BIT];
         end
      end
   end

   // pins pass two flops; edge detect looks only at the second
   // limitation: a pin held high through reset shows one rising edge
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pin0_sync <= 2'b00;
         pin1_sync <= 2'b00;
         pin0_prev <= 1'b0;
         pin1_prev <= 1'b0;
      end else begin
         pin0_sync <= {pin0_sync[0], ext_pin0_i};
         pin1_sync <= {pin1_sync[0], ext_pin1_i};
         pin0_prev <= pin0_sync[1];
         pin1_prev <= pin1_sync[1];
      end
   end

   // edge choice per pin; a pin low out of reset gives no false edge
   assign pin0_event = ext_pin0_edge_select ? (pin0_sync[1] && !pin0_prev)
      : (!pin0_sync[1] && pin0_prev);
   assign pin1_event = ext_pin1_edge_select ? (pin1_sync[1] && !pin1_prev)
      : (!pin1_sync[1] && pin1_prev);

   // hardware events
   always_comb begin
      event_set = `RESET_EVENTS;
      event_set[`EV_PIN0_EDGE] = pin0_event;
      event_set[`EV_PIN1_EDGE] = pin1_event;
      event_set[`EV_BASE_BLOCKED] = base_write && vector_lock_bit;
      event_set[`EV_LOCK_REFUSED] = lock_write && !lock_write_allowed;
   end

   // sticky status; a set in the clearing cycle wins
   // so an edge landing on a clear write is never lost
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         event_status <= `RESET_EVENTS;
      end else if (wr_hit(`IDX_EVENT_STATUS)) begin
         event_status <= (event_status & ~apb_req_i.pwdata[`EVENT_WIDTH-1:0]) | event_set;
      end else begin
         event_status <= event_status | event_set;
      end
   end

   // mask register
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         event_mask <= `RESET_EVENTS;
      end else if (wr_hit(`IDX_EVENT_MASK)) begin
         event_mask <= apb_req_i.pwdata[`EVENT_WIDTH-1:0];
      end
   end

   // service context tracking; high over low nests one level
   // high and low entry together from main: high wins
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ctx_state <= vic_pkg::CTX_MAIN;
      end else begin
         unique case (ctx_state)
            vic_pkg::CTX_MAIN: begin
               if (isr_enter_high_i) begin
                  ctx_state <= vic_pkg::CTX_HIGH_FROM_MAIN;
               end else if (isr_enter_low_i) begin
                  ctx_state <= vic_pkg::CTX_LOW;
               end
            end
            vic_pkg::CTX_LOW: begin
               // low routines do not nest, a low entry here is dropped
               if (isr_enter_high_i) begin
                  ctx_state <= vic_pkg::CTX_HIGH_FROM_LOW;
               end else if (isr_return_i) begin
                  ctx_state <= vic_pkg::CTX_MAIN;
               end
            end
            vic_pkg::CTX_HIGH_FROM_MAIN: begin
               // high priority cannot be preempted
               if (isr_return_i) begin
                  ctx_state <= vic_pkg::CTX_MAIN;
               end
            end
            vic_pkg::CTX_HIGH_FROM_LOW: begin
               // return resumes the interrupted low routine
               if (isr_return_i) begin
                  ctx_state <= vic_pkg::CTX_LOW;
               end
            end
         endcase
      end
   end

   // state code as seen by software
   always_comb begin
      unique case (ctx_state)
         vic_pkg::CTX_MAIN: interrupt_state_o = 2'b00;
         vic_pkg::CTX_LOW: interrupt_state_o = 2'b01;
         vic_pkg::CTX_HIGH_FROM_MAIN: interrupt_state_o = 2'b10;
         vic_pkg::CTX_HIGH_FROM_LOW: interrupt_state_o = 2'b11;
      endcase
   end

   // request forwarding; pin zero request comes from its sticky flag.
   // the enable only gates, the source keeps its own flag
   // bit 8 of the flag input is left unused
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         source_request_o <= 24'h000000;
      end else begin
         source_request_o[7:0] <= source_flag_i[7:0] & source_enable_bank0;
         source_request_o[15:9] <= source_flag_i[15:9] & source_enable_bank1[7:1];
         source_request_o[8] <= event_status[`EV_PIN0_EDGE]
            && source_enable_bank1[`BANK1_PIN0_BIT];
         source_request_o[23:16] <= source_flag_i[23:16] & source_enable_bank2;
      end
   end

   // outputs from flops
   assign vector_base_o = vector_table_base;
   assign vector_locked_o = vector_lock_bit;
   assign shadow_main_select_o = shadow_access_switch;
   assign irq_o = |(event_status & event_mask);

endmodule

// ==== logic/vic_pkg.sv ====
package vic_pkg;
   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;
   // apb answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_type;
   // service context of the core
   typedef enum logic [1:0] {
      CTX_MAIN,
      CTX_LOW,
      CTX_HIGH_FROM_MAIN,
      CTX_HIGH_FROM_LOW
   } ctx_state_type;
   // progress through the unlock sequence
   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_FIRST_SEEN,
      KEY_ARMED
   } key_state_type;
endpackage

// ==== logic/vic_regs.svh ====
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

// register indexes; byte address is four times the index
`define IDX_SHADOW_CONTEXT_SELECT 12'h376
`define IDX_VECTOR_BASE_LOCK 12'h459
`define IDX_VECTOR_TABLE_ADDRESS_READBACK 12'h45A
`define IDX_VECTOR_TABLE_BASE 12'h45D
`define IDX_SOURCE_ENABLE_BANK0 12'h4A8
`define IDX_SOURCE_ENABLE_BANK1 12'h4A9
`define IDX_SOURCE_ENABLE_BANK2 12'h4AA
`define IDX_EXT_EDGE_CONTROL 12'h4D6
`define IDX_INTERRUPT_STATE_STATUS 12'h4D7
`define IDX_EVENT_STATUS 12'h4E0
`define IDX_EVENT_MASK 12'h4E1
`define IDX_UNLOCK_KEY 12'h4E2

// field positions
`define STATE_FIELD_LSB 6
`define EDGE_PIN0_BIT 0
`define EDGE_PIN1_BIT 1
`define LOCK_BIT 0
`define SHADOW_SWITCH_BIT 0
`define BANK2_IMPL_MASK 8'hF1
`define BANK1_PIN0_BIT 0

// event status bits
`define EV_PIN0_EDGE 0
`define EV_PIN1_EDGE 1
`define EV_BASE_BLOCKED 2
`define EV_LOCK_REFUSED 3
`define EVENT_WIDTH 4

// unlock key bytes, written back to back
`define UNLOCK_KEY_FIRST 8'h55
`define UNLOCK_KEY_SECOND 8'hAA

// reset values
`define RESET_BYTE 8'h00
`define RESET_BASE 21'h000000
`define RESET_EVENTS 4'h0
`endif

// ==== tb/core_context_model.sv ====
`timescale 1ns/100ps
// stand-in for the processor core: context event pulses and entry vectors
module core_context_model (
   input wire logic core_clk_i,
   output logic isr_enter_high_o,
   output logic isr_enter_low_o,
   output logic isr_return_o,
   output logic [20:0] vector_address_o
);
   // all quiet at time zero
   initial begin
      isr_enter_high_o = 1'b0;
      isr_enter_low_o = 1'b0;
      isr_return_o = 1'b0;
      vector_address_o = 21'h000000;
   end
   // one-cycle pulse, 0 high entry, 1 low entry, 2 return
   task automatic pulse(input logic [1:0] kind, input logic [20:0] vec);
      @(posedge core_clk_i);
      isr_enter_high_o <= (kind == 2'd0);
      isr_enter_low_o <= (kind == 2'd1);
      isr_return_o <= (kind == 2'd2);
      vector_address_o <= vec;
      @(posedge core_clk_i);
      isr_enter_high_o <= 1'b0;
      isr_enter_low_o <= 1'b0;
      isr_return_o <= 1'b0;
      // the vector is only meaningful with an entry pulse, so scramble it after
      vector_address_o <= ~vec;
   endtask
endmodule

// ==== tb/vectored_interrupt_control_tb.sv ====
`timescale 1ns/100ps
`include "vic_regs.svh"
module vectored_interrupt_control_tb;
   logic core_clk_i, reset_i, pin0, pin1, one_way, ent_hi, ent_lo, ret, irq, locked, shad;
   logic [23:0] flags, reqs;
   logic [20:0] vec, base;
   logic [1:0] state;
   logic [31:0] q;
   logic e;
   vic_pkg::apb_req_type apb_req;
   vic_pkg::apb_rsp_type apb_rsp;
   int n_errors, checks_done;
   // short register index names
   localparam logic [11:0] I_SH = `IDX_SHADOW_CONTEXT_SELECT;
   localparam logic [11:0] I_LK = `IDX_VECTOR_BASE_LOCK;
   localparam logic [11:0] I_RB = `IDX_VECTOR_TABLE_ADDRESS_READBACK;
   localparam logic [11:0] I_BS = `IDX_VECTOR_TABLE_BASE;
   localparam logic [11:0] I_B0 = `IDX_SOURCE_ENABLE_BANK0;
   localparam logic [11:0] I_B1 = `IDX_SOURCE_ENABLE_BANK1;
   localparam logic [11:0] I_B2 = `IDX_SOURCE_ENABLE_BANK2;
   localparam logic [11:0] I_ED = `IDX_EXT_EDGE_CONTROL;
   localparam logic [11:0] I_ST = `IDX_INTERRUPT_STATE_STATUS;
   localparam logic [11:0] I_EV = `IDX_EVENT_STATUS;
   localparam logic [11:0] I_MK = `IDX_EVENT_MASK;
   localparam logic [11:0] I_KY = `IDX_UNLOCK_KEY;
   core_context_model u_core (.core_clk_i, .isr_enter_high_o(ent_hi), .isr_enter_low_o(ent_lo),
      .isr_return_o(ret), .vector_address_o(vec));
   vectored_interrupt_control u_dut (.core_clk_i, .reset_i, .apb_req_i(apb_req),
      .apb_rsp_o(apb_rsp), .ext_pin0_i(pin0), .ext_pin1_i(pin1), .source_flag_i(flags),
      .isr_enter_high_i(ent_hi), .isr_enter_low_i(ent_lo), .isr_return_i(ret),
      .vector_address_i(vec), .one_way_lock_i(one_way), .source_request_o(reqs),
      .vector_base_o(base), .vector_locked_o(locked), .shadow_main_select_o(shad),
      .interrupt_state_o(state), .irq_o(irq));
   // free-running 100 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
      @(posedge core_clk_i);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00}, pwdata: d};
      @(posedge core_clk_i);
      apb_req.penable <= 1'b1;
      // no wait count assumed; only the watchdog ends a hung access
      do begin
         @(posedge core_clk_i);
      end while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task wr(input logic [11:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask
   task rd(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h00000000);
      check(q, exp);
   endtask
   // key pair then the lock write, nothing in between
   task unlock(input logic v);
      wr(I_KY, {24'h000000, `UNLOCK_KEY_FIRST});
      wr(I_KY, {24'h000000, `UNLOCK_KEY_SECOND});
      wr(I_LK, {31'h00000000, v});
   endtask
   task done(input string nm);
      $display("test %s finished", nm);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #300000;
      n_errors++;
      end_of_test();
   end
   initial begin
      logic [11:0] regs [8];
      regs = '{I_SH, I_LK, I_RB, I_BS, I_B0, I_B1, I_B2, I_ST};
      apb_req = '0;
      {pin0, pin1, one_way, flags, reset_i} = {27'h0000000, 1'b1};
      n_errors = 0;
      checks_done = 0;
      repeat (3) @(posedge core_clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 8; i++) rd(regs[i], 32'h00000000);
      apb(1'b0, 12'hFFF, 32'h00000000);
      check({31'h00000000, e}, 32'h00000001);
      done("reset");
      // enables and request forwarding
      for (int i = 4; i < 7; i++) wr(regs[i], 32'hFFFFFFFF);
      rd(I_B0, 32'h000000FF);
      rd(I_B1, 32'h000000FF);
      rd(I_B2, 32'h000000F1);
      flags <= 24'hFFFFFF;
      repeat (3) @(posedge core_clk_i);
      check({8'h00, reqs}, 32'h00F1FEFF);
      wr(I_B0, 32'h00000000);
      repeat (2) @(posedge core_clk_i);
      check({8'h00, reqs}, 32'h00F1FE00);
      flags <= 24'h000000;
      done("enables");
      // vector base, readback and status are write-protected where read-only
      wr(I_BS, 32'hFFFFFFFF);
      rd(I_BS, 32'h001FFFFF);
      wr(I_RB, 32'hFFFFFFFF);
      rd(I_RB, 32'h00000000);
      wr(I_ST, 32'hFFFFFFFF);
      rd(I_ST, 32'h00000000);
      // lock without the key is refused, with it taken
      wr(I_LK, 32'h00000001);
      rd(I_LK, 32'h00000000);
      // key pair broken by a read: the lock write after it is refused
      wr(I_KY, {24'h000000, `UNLOCK_KEY_FIRST});
      wr(I_KY, {24'h000000, `UNLOCK_KEY_SECOND});
      rd(I_LK, 32'h00000000);
      wr(I_LK, 32'h00000001);
      rd(I_LK, 32'h00000000);
      unlock(1'b1);
      rd(I_LK, 32'h00000001);
      wr(I_BS, 32'h00012345);
      rd(I_BS, 32'h001FFFFF);
      rd(I_EV, 32'h0000000C);
      check({31'h00000000, irq}, 32'h00000000);
      wr(I_MK, 32'h00000004);
      repeat (2) @(posedge core_clk_i);
      check({31'h00000000, irq}, 32'h00000001);
      wr(I_EV, 32'h0000000F);
      repeat (2) @(posedge core_clk_i);
      check({31'h00000000, irq}, 32'h00000000);
      rd(I_EV, 32'h00000000);
      unlock(1'b0);
      rd(I_LK, 32'h00000000);
      wr(I_BS, 32'h000ABCDE);
      rd(I_BS, 32'h000ABCDE);
      check({11'h000, base}, 32'h000ABCDE);
      done("lock");
      // every edge-select combination, rising then falling on both pins
      for (int s = 0; s < 4; s++) begin
         wr(I_ED, s);
         wr(I_EV, 32'h0000000F);
         {pin1, pin0} <= 2'b11;
         repeat (6) @(posedge core_clk_i);
         rd(I_EV, s);
         check({31'h00000000, reqs[8]}, s & 1);
         wr(I_EV, 32'h0000000F);
         {pin1, pin0} <= 2'b00;
         repeat (6) @(posedge core_clk_i);
         rd(I_EV, 32'h00000003 ^ s);
      end
      wr(I_EV, 32'h0000000F);
      done("edges");
      // service contexts driven by the core model
      u_core.pulse(2'd1, 21'h001234);
      rd(I_ST, 32'h00000040);
      rd(I_RB, 32'h00001234);
      u_core.pulse(2'd0, 21'h1ABCDE);
      rd(I_ST, 32'h000000C0);
      u_core.pulse(2'd2, 21'h000000);
      u_core.pulse(2'd2, 21'h000000);
      rd(I_ST, 32'h00000000);
      u_core.pulse(2'd0, 21'h00ABCD);
      rd(I_ST, 32'h00000080);
      check({30'h00000000, state}, 32'h00000002);
      u_core.pulse(2'd2, 21'h000000);
      done("context");
      // shadow copy switch
      wr(I_SH, 32'h00000001);
      rd(I_SH, 32'h00000001);
      check({31'h00000000, shad}, 32'h00000001);
      wr(I_SH, 32'h00000000);
      rd(I_SH, 32'h00000000);
      check({31'h00000000, shad}, 32'h00000000);
      done("shadow");
      // second reset with the one-way setting on
      reset_i <= 1'b1;
      one_way <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(I_BS, 32'h00000000);
      unlock(1'b1);
      unlock(1'b0);
      rd(I_LK, 32'h00000001);
      check({31'h00000000, locked}, 32'h00000001);
      rd(I_EV, 32'h00000008);
      done("one_way");
      end_of_test();
   end
endmodule

// ==== tb/vic_checker_sva.sv ====
`timescale 1ns/100ps
module vic_checker (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire vic_pkg::apb_req_type apb_req_i,
   input wire logic isr_enter_high_i,
   input wire logic isr_enter_low_i,
   input wire logic [23:0] source_flag_i,
   input wire logic one_way_lock_i,
   input wire logic [23:0] source_request_o,
   input wire logic [20:0] vector_base_o,
   input wire logic vector_locked_o,
   input wire logic shadow_main_select_o,
   input wire logic [1:0] interrupt_state_o
);
   // byte addresses of the watched registers
   localparam logic [15:0] A_BASE = 16'h1174;
   localparam logic [15:0] A_LOCK = 16'h1164;
   localparam logic [15:0] A_SHADOW = 16'h0DD8;
   // access phase of a write, the edge where it lands
   logic acc_wr;
   assign acc_wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // write access to one register
   sequence s_wr(logic [15:0] a);
      acc_wr && (apb_req_i.paddr == a);
   endsequence
   property p_base_blocked;
      s_wr(A_BASE) ##0 vector_locked_o |=> $stable(vector_base_o);
   endproperty
   property p_base_open;
      s_wr(A_BASE) ##0 !vector_locked_o |=> vector_base_o == $past(apb_req_i.pwdata[20:0]);
   endproperty
   // lock moves only right after a lock write, reset edges excluded
   property p_lock_by_write;
      (vector_locked_o != $past(vector_locked_o)) && !$past(reset_i)
         |-> $past(acc_wr && (apb_req_i.paddr == A_LOCK));
   endproperty
   property p_one_way;
      one_way_lock_i && vector_locked_o |=> vector_locked_o;
   endproperty
   property p_shadow;
      s_wr(A_SHADOW) |=> shadow_main_select_o == $past(apb_req_i.pwdata[0]);
   endproperty
   property p_high_main;
      interrupt_state_o == 2'b00 && isr_enter_high_i |=> interrupt_state_o == 2'b10;
   endproperty
   property p_high_low;
      interrupt_state_o == 2'b01 && isr_enter_high_i |=> interrupt_state_o == 2'b11;
   endproperty
   property p_low_main;
      interrupt_state_o == 2'b00 && isr_enter_low_i && !isr_enter_high_i
         |=> interrupt_state_o == 2'b01;
   endproperty
   // no request without its flag; bit 8 comes from the pin, not the flags
   property p_gate;
      1'b1 |=> (source_request_o & ~$past(source_flag_i) & 24'hFFFEFF) == 24'h000000;
   endproperty
   property p_bank2_gap;
      source_request_o[19:17] == 3'b000;
   endproperty
   a_base_blocked: assert property (p_base_blocked) else $error("base moved while locked");
   a_base_open: assert property (p_base_open) else $error("base write lost");
   a_lock_by_write: assert property (p_lock_by_write) else $error("lock moved alone");
   a_one_way: assert property (p_one_way) else $error("one-way lock cleared");
   a_shadow: assert property (p_shadow) else $error("shadow switch wrong");
   a_high_main: assert property (p_high_main) else $error("state not 10");
   a_high_low: assert property (p_high_low) else $error("state not 11");
   a_low_main: assert property (p_low_main) else $error("state not 01");
   a_gate: assert property (p_gate) else $error("request without flag");
   a_bank2_gap: assert property (p_bank2_gap) else $error("request on gap bit");
endmodule
bind vectored_interrupt_control vic_checker u_checker (.core_clk_i, .reset_i, .apb_req_i,
   .isr_enter_high_i, .isr_enter_low_i, .source_flag_i, .one_way_lock_i, .source_request_o,
   .vector_base_o, .vector_locked_o, .shadow_main_select_o, .interrupt_state_o);
